// ===== verilog/dpw_pkg.sv
// How it works
// - Host selects array or flag space exclusively, held at least 12 ns.
// - Slave role: busy low no later than start of losing write.
// - Host blocked by busy keeps strobe low 12 ns after busy release; the host waits for busy seen low, after the synchroniser, at the end of its pulse.
// - Host changes address only while strobe or select is high.
// - Strobe write with drive-enable low stretches pulse past turn-off.
// - Host data valid 10 ns before write end, held 0 ns after.
package dpw_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_ENABLE_WRITE_NS = 12;
    localparam int T_DATA_SETUP_NS = 10;
    localparam int T_TURN_OFF_NS = 10;
    localparam int T_FLAG_READ_NS = 5;
    localparam int T_WRITE_HOLD_BUSY_NS = 12;
    localparam int T_PORT_DELAY_NS = 30;
    // Least times round up, never below one cycle.
    localparam int PULSE_NS = (T_ENABLE_WRITE_NS >
        T_TURN_OFF_NS + T_DATA_SETUP_NS) ? T_ENABLE_WRITE_NS :
        T_TURN_OFF_NS + T_DATA_SETUP_NS;
    localparam int PULSE_CYC = (PULSE_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int HOLD_CYC = (T_WRITE_HOLD_BUSY_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int FLAG_CYC = (T_FLAG_READ_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int XPORT_CYC = (T_PORT_DELAY_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam logic [3:0] CNT_W_ZERO = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b00_0001,
        ST_SETUP = 6'b00_0010,
        ST_PULSE = 6'b00_0100,
        ST_HOLD  = 6'b00_1000,
        ST_RDWT  = 6'b01_0000,
        ST_DONE  = 6'b10_0000
    } dpw_state_t;

    typedef struct packed {
        logic write;
        logic flag;
        logic [1:0] lanes;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dpw_req_t;

    typedef struct packed {
        logic port_select_n;
        logic flag_space_select_n;
        logic write_n;
        logic drive_enable_n;
        logic upper_lane_select_n;
        logic lower_lane_select_n;
        logic [15:0] addr;
    } dpw_pins_t;
endpackage

// ===== verilog/dpw_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of pin inputs.
module dpw_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Data.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // ------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------
    // The first stage is read only by the second.
    // Each bit resets to its INIT value, so a pin whose idle level INIT gives shows no false edge.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= INIT;
            q <= INIT;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// ===== verilog/dpw_host.sv
`timescale 1ns/1ps
// Host-side controller for one port of a two-port memory.
module dpw_host (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // User request.
    input wire logic req_valid,
    input wire dpw_pkg::dpw_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    // Memory port pins.
    output dpw_pkg::dpw_pins_t pins,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    input wire logic busy_n
);
    typedef struct packed {
        dpw_pkg::dpw_state_t st;
        dpw_pkg::dpw_req_t cur;
        dpw_pkg::dpw_pins_t pins;
        logic [15:0] dout;
        logic oe;
        logic [3:0] cnt;
        logic rdy;
        logic rv;
        logic [15:0] rd;
    } dpw_host_state_t;

    dpw_host_state_t s_ff;
    dpw_host_state_t nxt_s;
    logic [16:0] sync_q;
    logic busy_s;
    logic [15:0] din_s;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Busy and read data are asynchronous to mclk.
    // Busy resets to its idle high level, so no false busy edge follows reset.
    dpw_sync #(.W(17), .INIT(17'h1_0000)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d({busy_n, data_in}),
        .q(sync_q)
    );
    assign busy_s = ~sync_q[16];
    assign din_s = sync_q[15:0];

    localparam dpw_pkg::dpw_pins_t PINS_IDLE = '{
        port_select_n: 1'b1, flag_space_select_n: 1'b1,
        write_n: 1'b1, drive_enable_n: 1'b1,
        upper_lane_select_n: 1'b1, lower_lane_select_n: 1'b1,
        addr: 16'h0000};

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // One cycle each for setup and pulse; 40 ns already covers the 12 ns and 10 ns mins.
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rv = 1'b0;
        case (s_ff.st)
            dpw_pkg::ST_IDLE: begin
                nxt_s.rdy = 1'b1;
                if (req_valid && s_ff.rdy) begin
                    nxt_s.rdy = 1'b0;
                    nxt_s.cur = req;
                    // Address moves only with every select high.
                    nxt_s.pins = PINS_IDLE;
                    nxt_s.pins.addr = req.addr;
                    nxt_s.st = dpw_pkg::ST_SETUP;
                end
            end
            dpw_pkg::ST_SETUP: begin
                // Exclusive array or flag select.
                nxt_s.pins.port_select_n = s_ff.cur.flag;
                nxt_s.pins.flag_space_select_n = ~s_ff.cur.flag;
                nxt_s.pins.upper_lane_select_n = ~s_ff.cur.lanes[1];
                nxt_s.pins.lower_lane_select_n = ~s_ff.cur.lanes[0];
                nxt_s.pins.write_n = ~s_ff.cur.write;
                // Drive-enable stays high on writes so the device bus is free.
                nxt_s.pins.drive_enable_n = s_ff.cur.write;
                nxt_s.oe = s_ff.cur.write;
                nxt_s.dout = s_ff.cur.wdata; // Data set up with strobe.
                nxt_s.cnt = 4'(dpw_pkg::PULSE_CYC - 1);
                nxt_s.st = dpw_pkg::ST_PULSE;
            end
            dpw_pkg::ST_PULSE: begin
                // Pulse covers turn-off plus setup as well.
                if (s_ff.cnt != dpw_pkg::CNT_W_ZERO) begin
                    nxt_s.cnt = s_ff.cnt - 4'h1;
                end else if (busy_s && s_ff.cur.write) begin
                    // Blocked write: wait, then hold after release.
                    nxt_s.cnt = 4'(dpw_pkg::HOLD_CYC);
                    nxt_s.st = dpw_pkg::ST_HOLD;
                end else if (s_ff.cur.write) begin
                    nxt_s.pins = PINS_IDLE;
                    nxt_s.pins.addr = s_ff.cur.addr;
                    nxt_s.st = dpw_pkg::ST_DONE;
                end else begin
                    nxt_s.cnt = 4'(dpw_pkg::XPORT_CYC + 2);
                    nxt_s.st = dpw_pkg::ST_RDWT;
                end
            end
            dpw_pkg::ST_HOLD: begin
                if (busy_s) begin
                    nxt_s.cnt = 4'(dpw_pkg::HOLD_CYC);
                end else if (s_ff.cnt != dpw_pkg::CNT_W_ZERO) begin
                    nxt_s.cnt = s_ff.cnt - 4'h1;
                end else begin
                    nxt_s.pins = PINS_IDLE;
                    nxt_s.pins.addr = s_ff.cur.addr;
                    nxt_s.st = dpw_pkg::ST_DONE;
                end
            end
            dpw_pkg::ST_RDWT: begin
                // Wait out access and synchroniser latency before sampling.
                if (s_ff.cnt != dpw_pkg::CNT_W_ZERO) begin
                    nxt_s.cnt = s_ff.cnt - 4'h1;
                end else begin
                    nxt_s.rd = din_s;
                    nxt_s.pins = PINS_IDLE;
                    nxt_s.pins.addr = s_ff.cur.addr;
                    nxt_s.st = dpw_pkg::ST_DONE;
                end
            end
            dpw_pkg::ST_DONE: begin
                // Release the data bus a cycle after the strobe rises.
                nxt_s.oe = 1'b0;
                nxt_s.rv = 1'b1;
                nxt_s.rdy = 1'b1;
                nxt_s.st = dpw_pkg::ST_IDLE;
            end
            default: begin
                nxt_s.st = dpw_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Every state bit, pins included, changes only on mclk or on the asynchronous reset.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '{st: dpw_pkg::ST_IDLE, cur: '0, pins: PINS_IDLE,
                dout: 16'h0000, oe: 1'b0, cnt: 4'h0, rdy: 1'b0,
                rv: 1'b0, rd: 16'h0000};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs come straight from the state register, never from logic.
    assign req_ready = s_ff.rdy;
    assign rsp_valid = s_ff.rv;
    assign rsp_data = s_ff.rd;
    assign pins = s_ff.pins;
    assign data_out = s_ff.dout;
    assign data_oe = s_ff.oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Checks watch only what this block drives and the synchronised busy.
    sequence s_strobe_rise;
        $rose(pins.write_n);
    endsequence

    // A blocked write sits at the end of its pulse with busy seen.
    sequence s_write_blocked;
        s_ff.st == dpw_pkg::ST_PULSE && s_ff.cnt == dpw_pkg::CNT_W_ZERO &&
            s_ff.cur.write && busy_s;
    endsequence

    // The strobe stays low while the write waits for busy to clear.
    sequence s_strobe_held;
        s_ff.st == dpw_pkg::ST_HOLD && !pins.write_n;
    endsequence

    a_select_exclusive: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !(!pins.port_select_n && !pins.flag_space_select_n))
        else $error("array and flag selected together");
    a_addr_stable: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !$stable(pins.addr) |-> pins.write_n || pins.port_select_n)
        else $error("address moved during access");
    a_idle_pins: assert property (
        @(posedge mclk) disable iff (!rst_n)
        req_ready |-> pins.port_select_n && pins.flag_space_select_n)
        else $error("selects low while idle");
    a_data_held: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_strobe_rise |-> data_oe && $stable(data_out))
        else $error("write data not held at end of write");
    a_data_setup: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !pins.write_n |-> data_out == s_ff.cur.wdata)
        else $error("write data not presented during pulse");
    a_pulse_len: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_strobe_rise |-> $past(data_oe) && $past(pins.drive_enable_n))
        else $error("write pulse ended before data was driven");
    a_blocked_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_write_blocked |=> s_strobe_held)
        else $error("blocked write did not keep its strobe");
    a_busy_wait: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_ff.st == dpw_pkg::ST_HOLD && busy_s |=> !pins.write_n)
        else $error("strobe released while busy");
    a_busy_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        $fell(busy_s) && s_ff.st == dpw_pkg::ST_HOLD |->
        !pins.write_n [*2])
        else $error("strobe released too soon after busy");
    a_oe_write: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !pins.write_n |-> data_oe && pins.drive_enable_n)
        else $error("bus contention during write");
    a_read_no_drive: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !pins.drive_enable_n |-> !data_oe)
        else $error("host drives data while device may drive");
    a_rsp_ready: assert property (
        @(posedge mclk) disable iff (!rst_n)
        rsp_valid |-> req_ready && s_ff.st == dpw_pkg::ST_IDLE)
        else $error("response without ready");
    a_done_idle: assert property (
        @(posedge mclk) disable iff (!rst_n)
        s_ff.st == dpw_pkg::ST_DONE |-> ##1 rsp_valid ##1 !rsp_valid)
        else $error("response not one pulse");
endmodule

// ===== verif/dpw_dev_model.sv
`timescale 1ns/1ps
// Behavioural device port: word array, flag space and a busy input.
module dpw_dev_model (
    // Host pins.
    input wire dpw_pkg::dpw_pins_t pins,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    output logic [15:0] data_in,
    // Contention from the far port.
    input wire logic busy_n
);
    logic [15:0] mem [0:255];
    logic [7:0] flag;
    logic [15:0] rd;
    logic [15:0] last;
    logic rd_en;

    // Array starts at zero and every flag starts free.
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        flag = 8'hff;
        last = 16'h0000;
    end

    // Writes land during the overlap only, and never while busy is low.
    always @* begin
        if (!pins.write_n && busy_n && data_oe) begin
            if (!pins.port_select_n) begin
                if (!pins.upper_lane_select_n) begin
                    mem[pins.addr[7:0]][15:8] = data_out[15:8];
                end
                if (!pins.lower_lane_select_n) begin
                    mem[pins.addr[7:0]][7:0] = data_out[7:0];
                end
            end else if (!pins.flag_space_select_n) begin
                flag[pins.addr[2:0]] = data_out[0];
            end
        end
    end

    // A flag read repeats the flag on every bit, visible at once.
    assign rd_en = pins.write_n && !pins.drive_enable_n &&
        !(pins.port_select_n && pins.flag_space_select_n);
    assign rd = !pins.port_select_n ? mem[pins.addr[7:0]] :
        {16{flag[pins.addr[2:0]]}};

    // Released pins show the inverse of the last value, not a stale copy.
    always @* begin
        if (rd_en) begin
            last = rd;
        end
    end
    assign data_in = rd_en ? rd : ~last;
endmodule

// ===== verif/tb_dpw_host.sv
`timescale 1ns/1ps
module tb_dpw_host;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic busy_drv = 1'b1;
    dpw_pkg::dpw_req_t req = '0;
    logic req_ready, rsp_valid, data_oe;
    logic [15:0] rsp_data, data_in, data_out, d;
    dpw_pkg::dpw_pins_t pins;
    logic [15:0] shadow [0:255];
    logic [7:0] fshadow, a;
    logic [1:0] ln;
    logic [16:0] expq [$];
    logic [16:0] e;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;

    always #20 mclk = ~mclk;

    dpw_host u_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .pins(pins), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .busy_n(busy_drv));
    dpw_dev_model u_dev (.pins(pins), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in), .busy_n(busy_drv));

    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One access; the expected answer is noted before it can appear.
    task automatic xfer(input logic w, input logic f, input logic [1:0] l,
            input logic [7:0] ad, input logic [15:0] wd);
        while (req_ready !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
        req_valid = 1'b1;
        req = '{write: w, flag: f, lanes: l, addr: {8'h00, ad}, wdata: wd};
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        if (w && f) fshadow[ad[2:0]] = wd[0];
        if (w && !f && l[1]) shadow[ad][15:8] = wd[15:8];
        if (w && !f && l[0]) shadow[ad][7:0] = wd[7:0];
        expq.push_back({!w, f ? {16{fshadow[ad[2:0]]}} : shadow[ad]});
        while (rsp_valid !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
    endtask

    // --------------------------------------------------------------
    // Monitor and hang guard
    // --------------------------------------------------------------
    always @(posedge mclk) begin
        cyc++;
        if (rst_n && rsp_valid === 1'b1) begin
            if (expq.size() == 0) begin
                check("queue", 16'h0001, 16'h0000);
            end else begin
                e = expq.pop_front();
                if (e[16]) check("rsp_data", e[15:0], rsp_data);
            end
        end
        if (rst_n && pins.write_n === 1'b0) begin
            check("one_select", 16'h0001, 16'(pins.port_select_n ^
                pins.flag_space_select_n));
        end
        if (cyc == 6000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        foreach (shadow[i]) shadow[i] = 16'h0000;
        fshadow = 8'hff;
        void'($urandom(96147));
        repeat (12) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        // Random lanes on random words, each read back at once.
        for (int i = 0; i < 30; i++) begin
            a = 8'($urandom);
            d = 16'($urandom);
            ln = 2'($urandom);
            xfer(1'b1, 1'b0, ln, a, d);
            xfer(1'b0, 1'b0, 2'b11, a, 16'h0000);
        end
        $display("test lanes done");
        // Take and free every flag; only bit 0 of the word counts.
        for (int i = 0; i < 8; i++) begin
            d = 16'($urandom);
            xfer(1'b1, 1'b1, 2'b11, 8'(i), d & 16'hfffe);
            xfer(1'b0, 1'b1, 2'b11, 8'(i), 16'h0000);
            xfer(1'b1, 1'b1, 2'b11, 8'(i), d | 16'h0001);
            xfer(1'b0, 1'b1, 2'b11, 8'(i), 16'h0000);
        end
        $display("test flags done");
        // A write held off by busy must still land after release.
        fork
            xfer(1'b1, 1'b0, 2'b11, 8'h5a, 16'hc3a5);
            begin
                busy_drv = 1'b0; // Far port won the match.
                repeat (12) @(posedge mclk);
                #1;
                busy_drv = 1'b1;
            end
        join
        xfer(1'b0, 1'b0, 2'b11, 8'h5a, 16'h0000);
        // Let the monitor take the last response before the verdict.
        repeat (2) @(posedge mclk);
        #1;
        if (expq.size() != 0) check("drain", 16'h0000, 16'(expq.size()));
        $display("test busy done");
        end_of_test();
    end
endmodule
